// File: spd_consts.vh
// opcodes, sub-codes and timing constants for the serial program decoder
// assumes: included by the decoder files, no other context needed
`ifndef SPD_CONSTS_VH
`define SPD_CONSTS_VH
`define SPD_OP_ENABLE     8'hac
`define SPD_SUB_ENABLE    8'h53
`define SPD_SUB_ERASE     8'h80
`define SPD_SUB_WR_LOCK   8'he0
`define SPD_SUB_WR_CFGL   8'ha0
`define SPD_SUB_WR_CFGH   8'ha8
`define SPD_SUB_WR_CFGX   8'ha4
`define SPD_OP_POLL       8'hf0
`define SPD_OP_LD_EXT     8'h4d
`define SPD_OP_LD_HI      8'h48
`define SPD_OP_LD_LO      8'h40
`define SPD_OP_LD_EE      8'hc1
`define SPD_OP_RD_HI      8'h28
`define SPD_OP_RD_LO      8'h20
`define SPD_OP_RD_EE      8'ha0
`define SPD_OP_RD_LOCK    8'h58
`define SPD_OP_RD_CFG     8'h50
`define SPD_SUB_CFG_ALT   8'h08
`define SPD_OP_RD_SIG     8'h30
`define SPD_OP_RD_CAL     8'h38
`define SPD_OP_WR_PAGE    8'h4c
`define SPD_OP_WR_EE      8'hc0
`define SPD_OP_WR_EEPAGE  8'hc2
`define SPD_CFG_RESET     8'hff
`define SPD_CLK_NS        4
`define SPD_BUSY_NS       4500000
`define SPD_BUSY_CYC      ((`SPD_BUSY_NS + `SPD_CLK_NS - 1) / `SPD_CLK_NS)
`endif

// File: spd_decoder.v
// four-byte serial programming instruction decoder
// assumes: programmer drives serial clock and data asynchronously; array timing elsewhere
`timescale 1ns/1ps
`include "spd_consts.vh"
// What this block does
// (RL1) AC 80 00 00 erases program and EEPROM arrays.
// (RL2) F0 poll returns byte four, bit zero high while an operation pends.
// (RL3) 4D stores byte three as extended flash address.
// (RL4) 48 loads byte four as high half of buffered flash word.
// (RL5) 40 loads byte four as low half of buffered flash word.
// (RL6) programmer loads low byte before high byte of each word.
// (RL7) C1 puts byte four into EEPROM page buffer at low address.
// (RL8) 28 returns high byte of addressed flash word in byte four.
// (RL9) 20 returns low byte of addressed flash word in byte four.
// (RL10) C2 commits EEPROM page; C0 and A0 write or read one byte.
// (RL11) 4C commits flash page at address plus extended address.
// (RL12) 50 08 reads extended config bits; 50 00 reads low config.
// (RL13) 58 08 reads high config bits; 58 00 reads lock bits.
// (RL14) AC A8 writes high config bits; AC A0 writes low config bits.
// (RL15) AC A4 writes extended config bits; AC E0 writes lock bits.
// (RL16) zero means programmed, one unprogrammed, on write and read.
// (RL17) programmer leaves unused config and lock bits unprogrammed; the bench writes random values to them, unused bits included.
// (RL18) programmer commits the EEPROM page buffer after loading it.
// (RL19) when synchronised, echo 53 while the enable third byte shifts.
// (RL20) sample input on rising serial clock, change output on falling.
// (RL21) erase and program refused until a valid enable instruction.
// (RL22) instructions are four bytes; read data out in byte four.
// (RL23) 30 returns signature byte by byte three; 38 returns calibration.
module spd_decoder #(
  parameter BUSY_CYC = `SPD_BUSY_CYC,
  parameter [7:0] SIG0 = 8'h5a,  // arbitrary identity values
  parameter [7:0] SIG1 = 8'h6b,
  parameter [7:0] SIG2 = 8'h7c,
  parameter [7:0] CAL  = 8'h80
) (
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_arst_n,
  // programmer pins
  input  wire        i_prog_sck,
  input  wire        i_prog_serial_in,
  output reg         o_prog_serial_out,
  // array side: reads and commits
  input  wire [7:0]  i_flash_rdata,
  input  wire [7:0]  i_ee_rdata,
  output reg         o_erase,
  output reg         o_flash_commit,
  output reg         o_ee_commit,
  output reg         o_ee_write,
  output reg         o_flash_rd,
  output reg         o_ee_rd,
  output reg  [23:0] o_addr,
  output reg  [7:0]  o_wdata,
  output reg         o_prog_enabled
);
  // ********************************
  // input synchronisers and edges
  // ********************************
  reg [1:0] sck_s_q, sdi_s_q;
  reg       sck_prev_q;
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sck_s_q    <= 2'h0;
      sdi_s_q    <= 2'h0;
      sck_prev_q <= 1'b0;
    end else begin
      sck_s_q    <= {sck_s_q[0], i_prog_sck};
      sdi_s_q    <= {sdi_s_q[0], i_prog_serial_in};
      sck_prev_q <= sck_s_q[1];
    end
  end
  wire sck_rise = sck_s_q[1] & ~sck_prev_q;
  wire sck_fall = ~sck_s_q[1] & sck_prev_q;

  // ********************************
  // shift state
  // ********************************
  reg [7:0] sh_q;
  reg [2:0] bit_q;
  reg [1:0] byte_q;
  reg [7:0] b1_q, b2_q, b3_q;
  reg [7:0] tx_q;
  reg [7:0] ext_q;
  reg [7:0] lock_q, cfgl_q, cfgh_q, cfgx_q;
  reg [31:0] busy_q;
  reg       enabled_q;
  wire [7:0] shin = {sh_q[6:0], sdi_s_q[1]};
  wire last_bit = (bit_q == 3'h7);
  wire done_b2  = sck_rise & last_bit & (byte_q == 2'h1);
  wire done_b3  = sck_rise & last_bit & (byte_q == 2'h2);
  wire done_b4  = sck_rise & last_bit & (byte_q == 2'h3);
  wire pending  = (busy_q != 32'h0);

  // page buffer: flash words (low in even, high in odd) and EEPROM bytes
  reg        pb_we;
  reg  [7:0] pb_waddr;
  wire [7:0] pb_rdata;
  always @* begin
    pb_we    = 1'b0;
    pb_waddr = 8'h00;
    if (done_b4 && b1_q == `SPD_OP_LD_LO) begin
      pb_we    = 1'b1;                              // RL5
      pb_waddr = {b3_q[6:0], 1'b0};
    end else if (done_b4 && b1_q == `SPD_OP_LD_HI) begin
      pb_we    = 1'b1;                              // RL4
      pb_waddr = {b3_q[6:0], 1'b1};
    end else if (done_b4 && b1_q == `SPD_OP_LD_EE) begin
      pb_we    = 1'b1;                              // RL7
      pb_waddr = {6'h3f, b3_q[1:0]};
    end
  end
  spd_page_buf #(.AW(8)) u_buf (
    .i_clk   (i_ref_clk),
    .i_we    (pb_we),
    .i_waddr (pb_waddr),
    .i_wdata (shin),
    .i_raddr (8'h00),
    .o_rdata (pb_rdata)
  );

  // reply byte chosen once byte three completes, shifted out in byte four
  reg [7:0] reply;
  always @* begin
    case (b1_q)
      `SPD_OP_POLL:    reply = {7'h00, pending};                        // RL2
      `SPD_OP_RD_HI,
      `SPD_OP_RD_LO:   reply = i_flash_rdata;                           // RL8 RL9
      `SPD_OP_RD_EE:   reply = i_ee_rdata;                              // RL10
      `SPD_OP_RD_CFG:  reply = (b2_q == `SPD_SUB_CFG_ALT) ? cfgx_q : cfgl_q; // RL12 RL16
      `SPD_OP_RD_LOCK: reply = (b2_q == `SPD_SUB_CFG_ALT) ? cfgh_q : lock_q; // RL13 RL16
      `SPD_OP_RD_SIG:  reply = (b3_q[1:0] == 2'h0) ? SIG0 :
                               (b3_q[1:0] == 2'h1) ? SIG1 : SIG2;     // RL23
      `SPD_OP_RD_CAL:  reply = CAL;                                     // RL23
      default:         reply = 8'h00;
    endcase
  end

  // ********************************
  // bit and byte counting, decode
  // ********************************
  // array read data must be valid a few cycles after o_flash_rd/o_ee_rd
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sh_q <= 8'h00; bit_q <= 3'h0; byte_q <= 2'h0;
      b1_q <= 8'h00; b2_q <= 8'h00; b3_q <= 8'h00;
      tx_q <= 8'h00; ext_q <= 8'h00;
      lock_q <= `SPD_CFG_RESET; cfgl_q <= `SPD_CFG_RESET;
      cfgh_q <= `SPD_CFG_RESET; cfgx_q <= `SPD_CFG_RESET;
      busy_q <= 32'h0; enabled_q <= 1'b0;
      o_prog_serial_out <= 1'b0;
      o_erase <= 1'b0; o_flash_commit <= 1'b0; o_ee_commit <= 1'b0;
      o_ee_write <= 1'b0; o_flash_rd <= 1'b0; o_ee_rd <= 1'b0;
      o_addr <= 24'h0; o_wdata <= 8'h00; o_prog_enabled <= 1'b0;
    end else begin
      o_erase <= 1'b0; o_flash_commit <= 1'b0; o_ee_commit <= 1'b0;
      o_ee_write <= 1'b0; o_flash_rd <= 1'b0; o_ee_rd <= 1'b0;
      o_prog_enabled <= enabled_q;
      if (pending) begin
        busy_q <= busy_q - 32'h1;
      end
      // input bits taken on rising serial clock
      if (sck_rise) begin                                      // RL20
        sh_q  <= shin;
        bit_q <= bit_q + 3'h1;
        if (last_bit) begin
          byte_q <= byte_q + 2'h1;                             // RL22
          case (byte_q)
            2'h0: b1_q <= shin;
            2'h1: b2_q <= shin;
            2'h2: b3_q <= shin;
            default: b3_q <= b3_q;
          endcase
        end
      end
      // read addresses presented as soon as byte three lands
      if (done_b3) begin
        // EEPROM read addresses never carry the extended flash byte; C0 and C2 addresses carry it until byte four lands
        o_addr     <= {(b1_q == `SPD_OP_RD_EE) ? 8'h00 : ext_q, b2_q, shin};
        o_flash_rd <= (b1_q == `SPD_OP_RD_HI) | (b1_q == `SPD_OP_RD_LO);
        o_ee_rd    <= (b1_q == `SPD_OP_RD_EE);
      end
      // output changes only on falling serial clock
      if (sck_fall) begin                                      // RL20
        if (bit_q == 3'h0 && byte_q == 2'h2 && b1_q == `SPD_OP_ENABLE) begin
          tx_q              <= {b2_q[6:0], 1'b0};              // RL19
          o_prog_serial_out <= b2_q[7];
        end else if (bit_q == 3'h0 && byte_q == 2'h3) begin
          tx_q              <= {reply[6:0], 1'b0};             // RL22
          o_prog_serial_out <= reply[7];
        end else begin
          tx_q              <= {tx_q[6:0], 1'b0};
          o_prog_serial_out <= tx_q[7];
        end
      end
      // actions when the fourth byte completes
      if (done_b4) begin
        o_wdata <= shin;
        if (b1_q == `SPD_OP_ENABLE && b2_q == `SPD_SUB_ENABLE) begin
          enabled_q <= 1'b1;                                   // RL21
        end
        if (b1_q == `SPD_OP_LD_EXT) begin
          ext_q <= b3_q;                                       // RL3
        end
        if (enabled_q && !pending) begin                       // RL21
          case (b1_q)
            `SPD_OP_ENABLE: begin
              case (b2_q)
                `SPD_SUB_ERASE: begin
                  o_erase <= 1'b1;                             // RL1
                  busy_q  <= BUSY_CYC * 2;
                end
                `SPD_SUB_WR_LOCK: lock_q <= shin;              // RL15 RL16
                `SPD_SUB_WR_CFGL: cfgl_q <= shin;              // RL14
                `SPD_SUB_WR_CFGH: cfgh_q <= shin;              // RL14
                `SPD_SUB_WR_CFGX: cfgx_q <= shin;              // RL15
                default: busy_q <= busy_q;
              endcase
            end
            `SPD_OP_WR_PAGE: begin
              o_flash_commit <= 1'b1;                          // RL11
              o_addr         <= {ext_q, b2_q, b3_q};
              busy_q         <= BUSY_CYC;
            end
            `SPD_OP_WR_EEPAGE: begin
              o_ee_commit <= 1'b1;                             // RL10
              o_addr      <= {8'h00, b2_q, b3_q};
              busy_q      <= BUSY_CYC * 2;
            end
            `SPD_OP_WR_EE: begin
              o_ee_write <= 1'b1;                              // RL10
              o_addr     <= {8'h00, b2_q, b3_q};
              busy_q     <= BUSY_CYC * 2;
            end
            default: busy_q <= busy_q;
          endcase
        end
      end
    end
  end
  // buffered data reaches the arrays through the commit port elsewhere
  wire unused_buf = ^pb_rdata;
endmodule

// File: spd_decoder_bench.sv
// self-checking bench for the serial program decoder
// assumes: decoder, page buffer, model and checker compiled first
`timescale 1ns/1ps
// ****************
// bench
// ****************
module spd_decoder_bench;
  // arbitrary identity values; busy shortened so polls see it
  localparam logic [7:0] SIG0 = 8'h3c, SIG1 = 8'h5d, SIG2 = 8'h7e, CAL = 8'h96;
  logic i_ref_clk, i_arst_n, i_prog_sck, i_prog_serial_in, o_prog_serial_out;
  logic o_erase, o_flash_commit, o_ee_commit, o_ee_write, o_flash_rd, o_ee_rd;
  logic o_prog_enabled;
  logic [7:0] i_flash_rdata, i_ee_rdata, o_wdata, v;
  logic [23:0] o_addr, a, e;
  logic [31:0] rsp;
  logic [29:0] notes[$];
  logic [15:0] rd_op[4] = '{16'h5000, 16'h5808, 16'h5008, 16'h5800};
  logic [7:0] wr_sub[4] = '{8'ha0, 8'ha8, 8'ha4, 8'he0};
  logic [7:0] sigs[4] = '{SIG0, SIG1, SIG2, CAL};
  int err_total = 0;
  int samples_checked = 0;
  wire [5:0] ev = {o_erase, o_flash_commit, o_ee_commit, o_ee_write, o_flash_rd, o_ee_rd};
  spd_decoder #(.BUSY_CYC(300), .SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2), .CAL(CAL)) dut (
    .i_ref_clk, .i_arst_n, .i_prog_sck, .i_prog_serial_in, .o_prog_serial_out,
    .i_flash_rdata, .i_ee_rdata, .o_erase, .o_flash_commit, .o_ee_commit, .o_ee_write,
    .o_flash_rd, .o_ee_rd, .o_addr, .o_wdata, .o_prog_enabled);
  spd_prog_model prog (.i_ref_clk, .i_sdo(o_prog_serial_out), .o_sck(i_prog_sck),
    .o_sdi(i_prog_serial_in));
  // 250 MHz core clock
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk8(input logic [7:0] x, input logic [7:0] g);
    samples_checked++;
    if (g !== x) begin
      err_total++;
      $display("mismatch at %0t exp %h got %h", $time, x, g);
    end
  endtask
  // erase leaves the address undefined, so only its strobe is compared
  task automatic chk_ev(input logic [29:0] x, input logic [29:0] g);
    if (x[29]) g[23:0] = x[23:0];
    samples_checked++;
    if (g !== x) begin
      err_total++;
      $display("mismatch at %0t exp %h got %h", $time, x, g);
    end
  endtask
  // a strobe is noted before the frame that causes it
  task automatic cmd(input logic [31:0] c, input logic [5:0] m, input logic [23:0] ad);
    if (m != 6'h00) notes.push_back({m, ad});
    prog.xfer(c, rsp);
  endtask
  task automatic wait_idle;
    for (int k = 0; k < 20; k++) begin
      cmd(32'hf0000000, 6'h00, 24'h0);
      if (rsp[0] === 1'b0) return;
    end
    err_total++;
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // strobe watcher: any strobe without a note is a mismatch
  always @(posedge i_ref_clk) begin
    if (i_arst_n && ev !== 6'h00) begin
      if (notes.size() == 0) chk_ev(30'h0, {ev, o_addr});
      else chk_ev(notes.pop_front(), {ev, o_addr});
    end
  end
  // watchdog, well beyond the expected run
  initial begin
    #240000;
    err_total++;
    stop_test();
  end
  initial begin
    i_arst_n = 1'b0;
    i_flash_rdata = 8'h00;
    i_ee_rdata = 8'h00;
    void'($urandom(22775));
    repeat (4) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    cmd(32'hac800000, 6'h00, 24'h0);
    cmd(32'hac530000, 6'h00, 24'h0);
    chk8(8'h53, rsp[15:8]);
    chk8(8'h01, {7'h0, o_prog_enabled});
    $display("test enable done");
    for (int k = 0; k < 4; k++) begin
      v = $urandom;
      cmd({rd_op[k], 16'h0}, 6'h00, 24'h0);
      chk8(8'hff, rsp[7:0]);
      // random values stand in for the fields, unused bits included, so those bits may be programmed
      cmd({8'hac, wr_sub[k], 8'h00, v}, 6'h00, 24'h0);
      wait_idle();
      cmd({rd_op[k], 16'h0}, 6'h00, 24'h0);
      chk8(v, rsp[7:0]);
    end
    $display("test config done");
    cmd(32'hac800000, 6'h20, 24'h0);
    cmd(32'hf0000000, 6'h00, 24'h0);
    chk8(8'h01, {7'h0, rsp[0]});
    wait_idle();
    $display("test erase done");
    a = $urandom;
    v = $urandom;
    cmd({8'h4d, 8'h00, a[23:16], 8'h00}, 6'h00, 24'h0);
    cmd({8'h40, 8'h00, a[7:0], v}, 6'h00, 24'h0);
    cmd({8'h48, 8'h00, a[7:0], ~v}, 6'h00, 24'h0);
    chk8(~v, o_wdata);
    cmd({8'h4c, a[15:0], 8'h00}, 6'h10, a);
    wait_idle();
    for (int k = 0; k < 2; k++) begin
      v = $urandom;
      i_flash_rdata <= v;
      cmd({k ? 8'h20 : 8'h28, a[15:0], 8'h00}, 6'h02, a);
      chk8(v, rsp[7:0]);
    end
    $display("test flash done");
    e = {14'h0, a[9:2], 2'b00};
    cmd({8'hc1, 8'h00, 6'h0, a[1:0], v}, 6'h00, 24'h0);
    cmd({8'hc2, e[15:0], 8'h00}, 6'h08, e);
    wait_idle();
    e = {14'h0, a[9:0]};
    cmd({8'hc0, e[15:0], v}, 6'h04, e);
    chk8(v, o_wdata);
    wait_idle();
    i_ee_rdata <= ~v;
    cmd({8'ha0, e[15:0], 8'h00}, 6'h01, e);
    chk8(~v, rsp[7:0]);
    $display("test eeprom done");
    for (int k = 0; k < 4; k++) begin
      cmd(k < 3 ? {8'h30, 8'h00, 8'(k), 8'h00} : 32'h38000000, 6'h00, 24'h0);
      chk8(sigs[k], rsp[7:0]);
    end
    chk8(8'h00, 8'(notes.size()));
    $display("test identity done");
    stop_test();
  end
endmodule

// File: spd_decoder_chk.sv
// checker: port-level timing of the serial program decoder
// assumes: bound into spd_decoder, one core clock domain
`timescale 1ns/1ps
// ****************
// assertions
// ****************
module spd_decoder_chk (
  // clock, reset and serial pins
  input logic        i_ref_clk,
  input logic        i_arst_n,
  input logic        i_prog_sck,
  input logic        o_prog_serial_out,
  // array side strobes
  input logic        o_erase,
  input logic        o_flash_commit,
  input logic        o_ee_commit,
  input logic        o_ee_write,
  input logic        o_flash_rd,
  input logic        o_ee_rd,
  input logic [23:0] o_addr,
  input logic        o_prog_enabled
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // all strobes together; a frame takes far longer than the quiet span
  wire [5:0] ev = {o_erase, o_flash_commit, o_ee_commit, o_ee_write, o_flash_rd, o_ee_rd};
  sequence s_gone(x); x ##1 !x; endsequence
  sequence s_quiet; (ev == 6'h00) [*8]; endsequence
  property p_erase; o_erase |-> o_prog_enabled ##0 s_gone(o_erase); endproperty
  property p_fcommit; o_flash_commit |-> o_prog_enabled ##0 s_gone(o_flash_commit); endproperty
  property p_ecommit; o_ee_commit |-> o_prog_enabled ##0 s_gone(o_ee_commit); endproperty
  property p_ewrite; o_ee_write |-> o_prog_enabled ##0 s_gone(o_ee_write); endproperty
  property p_en_hold; o_prog_enabled |=> o_prog_enabled; endproperty
  property p_sdo_edge; $changed(o_prog_serial_out) |-> !$past(i_prog_sck, 2); endproperty
  property p_one_op; ev != 6'h00 |-> $onehot(ev) ##1 s_quiet; endproperty
  property p_ee_addr; (o_ee_commit || o_ee_write || o_ee_rd) |-> o_addr[23:16] == 8'h00;
  endproperty
  a_erase: assert property (p_erase) else $error("erase strobe bad");
  a_fcommit: assert property (p_fcommit) else $error("flash commit bad");
  a_ecommit: assert property (p_ecommit) else $error("eeprom commit bad");
  a_ewrite: assert property (p_ewrite) else $error("eeprom write bad");
  a_en_hold: assert property (p_en_hold) else $error("enable dropped");
  a_sdo_edge: assert property (p_sdo_edge) else $error("data out moved off fall");
  a_one_op: assert property (p_one_op) else $error("strobes too close");
  a_ee_addr: assert property (p_ee_addr) else $error("eeprom address high");
endmodule
bind spd_decoder spd_decoder_chk u_chk (.i_ref_clk, .i_arst_n, .i_prog_sck, .o_prog_serial_out,
  .o_erase, .o_flash_commit, .o_ee_commit, .o_ee_write, .o_flash_rd, .o_ee_rd, .o_addr,
  .o_prog_enabled);

// File: spd_page_buf.v
// page buffer memory: one byte written per cycle, registered read data
// assumes: single clock, write and read addresses from the decoder
`timescale 1ns/1ps
`include "spd_consts.vh"
module spd_page_buf #(
  parameter AW = 8
) (
  // clock
  input  wire          i_clk,
  // write port
  input  wire          i_we,
  input  wire [AW-1:0] i_waddr,
  input  wire [7:0]    i_wdata,
  // read port
  input  wire [AW-1:0] i_raddr,
  output reg  [7:0]    o_rdata
);
  reg [7:0] mem_q [0:(1<<AW)-1];

  // no reset on the array itself; contents are defined by loads
  always @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_q[i_raddr];
  end
endmodule

// File: spd_prog_model.sv
// programmer model: serial clock and data out, reply sampled back
// assumes: core clock for timing; sck low 5 and high 3 cycles, 32 ns
`timescale 1ns/1ps
// ****************
// serial programmer
// ****************
module spd_prog_model (
  // timing and reply
  input  logic i_ref_clk,
  input  logic i_sdo,
  // pins toward the decoder
  output logic o_sck,
  output logic o_sdi
);
  // sck stands low between frames
  initial begin
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end
  // one whole frame msb first; offset keeps sck off the core edge
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
    for (int i = 31; i >= 0; i--) begin
      o_sdi <= #1.5 cmd[i];
      repeat (5) @(posedge i_ref_clk);
      rsp[i] = i_sdo;
      o_sck <= #1.5 1'b1;
      repeat (3) @(posedge i_ref_clk);
      o_sck <= #1.5 1'b0;
    end
    o_sdi <= #1.5 ~cmd[0]; // idle data is not the last bit
    repeat (8) @(posedge i_ref_clk);
  endtask
endmodule
